// File: design/pioscn_pkg.sv
// pioscn_pkg: constants, carriers and tap states for the pin cell array
// assumes: one core clock, software on a plain address/strobe register port
package pioscn_pkg;

	// array size and scan layout
	localparam int PIN_N   = 8;
	localparam int CELL_N  = 3;                 // input, output, enable cell per pin
	localparam int BSR_LEN = CELL_N * PIN_N;
	localparam int CELL_IN = 0;
	localparam int CELL_DO = 1;
	localparam int CELL_OE = 2;

	// scan defaults, overridable at the top module, plus the fixed ir capture code
	localparam int          IR_LEN_DEF  = 4;
	localparam logic [7:0]  OP_EXT_DEF  = 8'h00;
	localparam logic [7:0]  OP_SMP_DEF  = 8'h05;
	localparam logic [7:0]  OP_BYP_DEF  = 8'hff;
	localparam logic        BSR_REV_DEF = 1'b0;
	localparam logic        DIS_POL_DEF = 1'b1;
	localparam logic [1:0]  IR_CAP_VAL  = 2'b01;

	// register port
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam logic [7:0]  REG_DIR_OUT = 8'h00;
	localparam logic [7:0]  REG_DIR_IN  = 8'h04;
	localparam logic [7:0]  REG_INV_D   = 8'h08;
	localparam logic [7:0]  REG_INV_OE  = 8'h0c;
	localparam logic [7:0]  REG_OD      = 8'h10;
	localparam logic [7:0]  REG_SRC_ADJ = 8'h14;
	localparam logic [7:0]  REG_FAST    = 8'h18;
	localparam logic [7:0]  REG_CTRL    = 8'h1c;
	localparam logic [7:0]  REG_STATUS  = 8'h20;
	localparam logic [7:0]  REG_PIN_IN  = 8'h24;

	// field positions and reset values
	localparam int          CTRL_BUSY   = 0;
	localparam int          CTRL_SCNOFF = 1;
	localparam int          STAT_PWR    = 0;
	localparam int          STAT_DIS    = 1;
	localparam int          STAT_IR     = 8;
	localparam int          STAT_TAP    = 16;
	localparam logic [7:0]  CFG_RST     = 8'h00;
	localparam logic [1:0]  CTRL_RST    = 2'h0;

	// logic cell side drive of every pin
	typedef struct packed {
		logic [PIN_N-1:0] route_data;
		logic [PIN_N-1:0] route_oe;
		logic [PIN_N-1:0] adj_data;
		logic [PIN_N-1:0] adj_oe;
	} pioscn_lc_t;

	// pad side drive
	typedef struct packed {
		logic [PIN_N-1:0] out;
		logic [PIN_N-1:0] oe;
	} pioscn_pad_t;

	// test access port controller states
	typedef enum logic [15:0] {
		TAP_TLR   = 16'h0001,
		TAP_RTI   = 16'h0002,
		TAP_SELDR = 16'h0004,
		TAP_CAPDR = 16'h0008,
		TAP_SHDR  = 16'h0010,
		TAP_EX1DR = 16'h0020,
		TAP_PADR  = 16'h0040,
		TAP_EX2DR = 16'h0080,
		TAP_UPDDR = 16'h0100,
		TAP_SELIR = 16'h0200,
		TAP_CAPIR = 16'h0400,
		TAP_SHIR  = 16'h0800,
		TAP_EX1IR = 16'h1000,
		TAP_PAIR  = 16'h2000,
		TAP_EX2IR = 16'h4000,
		TAP_UPDIR = 16'h8000
	} pioscn_tap_t;

endpackage : pioscn_pkg

// File: design/pioscn_top.sv
// pioscn_top: pin cell array with boundary scan and configuration registers
// assumes: tck/tms/tdi are sampled on core_clk_i, far slower than it
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - each pin: input buffer plus tri-state driver; input, output or both
// - pin data comes from local routing or directly from adjacent logic cell
// - fast pin variant takes data only from the adjacent logic cell
// - each pin owns its enable, routed the same way as its data
// - data and enable each have a selectable inversion
// - open-drain: data tied low, enable switched by the user
// - open-drain pin only drives low or floats, never high
// - chip-wide output disable floats every pin regardless of enables
// - no pin is driven until operating conditions are reached
// - test port and scan logic follow the 1149.1-1990 standard
// - scan refused while configuration is in progress
// - sample/preload snapshots pins and preloads a pattern, no disturbance
// - extest drives scanned pattern on outputs, captures inputs
// - bypass puts a one-bit register between tdi and tdo
module pioscn_top
	import pioscn_pkg::*;
#(
	parameter int                   IR_W    = IR_LEN_DEF,
	parameter logic [IR_LEN_DEF-1:0] OP_EXT = OP_EXT_DEF[IR_LEN_DEF-1:0],
	parameter logic [IR_LEN_DEF-1:0] OP_SMP = OP_SMP_DEF[IR_LEN_DEF-1:0],
	parameter logic [IR_LEN_DEF-1:0] OP_BYP = OP_BYP_DEF[IR_LEN_DEF-1:0],
	parameter logic                 BSR_REV = BSR_REV_DEF,
	parameter logic                 DIS_POL = DIS_POL_DEF
) (
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              resetn_i,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output var  logic [DATA_W-1:0] reg_rdata_o,
	// logic cell side
	input  wire pioscn_lc_t        lc_drive_i,
	output var  logic [PIN_N-1:0]  core_in_o,
	// pads
	input  wire logic [PIN_N-1:0]  pin_in_i,
	output var  pioscn_pad_t       pad_o,
	// chip level
	input  wire logic              chip_wide_output_disable_i,
	input  wire logic              supply_ok_i,
	// test access port
	input  wire logic              tck_i,
	input  wire logic              tms_i,
	input  wire logic              tdi_i,
	output var  logic              tdo_o,
	output var  logic              tdo_oe_o
);

	// whole state of the block
	typedef struct packed {
		logic [PIN_N-1:0]   dir_out;
		logic [PIN_N-1:0]   dir_in;
		logic [PIN_N-1:0]   inv_d;
		logic [PIN_N-1:0]   inv_oe;
		logic [PIN_N-1:0]   od;
		logic [PIN_N-1:0]   src_adj;
		logic [PIN_N-1:0]   fast;
		logic [1:0]         ctrl;
		logic [DATA_W-1:0]  rdata;
		logic               tck_q;
		pioscn_tap_t        tap;
		logic [IR_W-1:0]    ir_sh;
		logic [IR_W-1:0]    ir;
		logic               byp;
		logic [BSR_LEN-1:0] bsr_sh;
		logic [BSR_LEN-1:0] bsr_up;
		logic               tdo;
		logic               tdo_oe;
		pioscn_pad_t        pad;
		logic [PIN_N-1:0]   core_in;
	} pioscn_st_t;

	pioscn_st_t s_r;
	pioscn_st_t s_nxt;

	// address decode shared by write and read
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	// tap controller transition table
	function automatic pioscn_tap_t tap_step(input pioscn_tap_t t, input logic m);
		unique case (t)
			TAP_TLR:   tap_step = m ? TAP_TLR   : TAP_RTI;
			TAP_RTI:   tap_step = m ? TAP_SELDR : TAP_RTI;
			TAP_SELDR: tap_step = m ? TAP_SELIR : TAP_CAPDR;
			TAP_CAPDR: tap_step = m ? TAP_EX1DR : TAP_SHDR;
			TAP_SHDR:  tap_step = m ? TAP_EX1DR : TAP_SHDR;
			TAP_EX1DR: tap_step = m ? TAP_UPDDR : TAP_PADR;
			TAP_PADR:  tap_step = m ? TAP_EX2DR : TAP_PADR;
			TAP_EX2DR: tap_step = m ? TAP_UPDDR : TAP_SHDR;
			TAP_UPDDR: tap_step = m ? TAP_SELDR : TAP_RTI;
			TAP_SELIR: tap_step = m ? TAP_TLR   : TAP_CAPIR;
			TAP_CAPIR: tap_step = m ? TAP_EX1IR : TAP_SHIR;
			TAP_SHIR:  tap_step = m ? TAP_EX1IR : TAP_SHIR;
			TAP_EX1IR: tap_step = m ? TAP_UPDIR : TAP_PAIR;
			TAP_PAIR:  tap_step = m ? TAP_EX2IR : TAP_PAIR;
			TAP_EX2IR: tap_step = m ? TAP_UPDIR : TAP_SHIR;
			TAP_UPDIR: tap_step = m ? TAP_SELDR : TAP_RTI;
			default:   tap_step = TAP_TLR;
		endcase
	endfunction : tap_step

	// decoded helpers
	logic               tck_rise;
	logic               tck_fall;
	logic               scan_hold;
	logic               bsr_sel;
	logic               dis_act;
	logic [PIN_N-1:0]   core_d;
	logic [PIN_N-1:0]   core_oe;
	logic [PIN_N-1:0]   ext_d;
	logic [PIN_N-1:0]   ext_oe;
	logic [PIN_N-1:0]   sh_in;
	logic [BSR_LEN-1:0] cap_vec;

	assign tck_rise  = tck_i & ~s_r.tck_q;
	assign tck_fall  = ~tck_i & s_r.tck_q;
	assign scan_hold = s_r.ctrl[CTRL_BUSY] | s_r.ctrl[CTRL_SCNOFF];
	assign bsr_sel   = (s_r.ir == OP_EXT) || (s_r.ir == OP_SMP);
	assign dis_act   = (chip_wide_output_disable_i == DIS_POL);

	// per-pin core path and scan cell taps
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_pin
			logic use_adj;
			// fast pins are hard-wired to the adjacent logic cell
			assign use_adj = s_r.fast[gi] | s_r.src_adj[gi];
			assign core_d[gi]  = (use_adj ? lc_drive_i.adj_data[gi]
			                              : lc_drive_i.route_data[gi]) ^ s_r.inv_d[gi];
			// enable follows the same route as the data
			assign core_oe[gi] = ((use_adj ? lc_drive_i.adj_oe[gi]
			                               : lc_drive_i.route_oe[gi]) ^ s_r.inv_oe[gi])
			                     & s_r.dir_out[gi];
			assign ext_d[gi]   = s_r.bsr_up[CELL_N*gi+CELL_DO];
			assign ext_oe[gi]  = s_r.bsr_up[CELL_N*gi+CELL_OE];
			assign sh_in[gi]   = s_r.bsr_sh[CELL_N*gi+CELL_IN];
			assign cap_vec[CELL_N*gi+CELL_IN] = pin_in_i[gi];
			assign cap_vec[CELL_N*gi+CELL_DO] = core_d[gi];
			assign cap_vec[CELL_N*gi+CELL_OE] = core_oe[gi];
		end
	endgenerate

	// next state of the whole block
	always_comb begin
		s_nxt       = s_r;
		s_nxt.rdata = '0;
		s_nxt.tck_q = tck_i;

		// register writes
		if (reg_wr_i) begin
			if (hit(reg_addr_i, REG_DIR_OUT)) s_nxt.dir_out = reg_wdata_i[PIN_N-1:0];
			if (hit(reg_addr_i, REG_DIR_IN))  s_nxt.dir_in  = reg_wdata_i[PIN_N-1:0];
			if (hit(reg_addr_i, REG_INV_D))   s_nxt.inv_d   = reg_wdata_i[PIN_N-1:0];
			if (hit(reg_addr_i, REG_INV_OE))  s_nxt.inv_oe  = reg_wdata_i[PIN_N-1:0];
			if (hit(reg_addr_i, REG_OD))      s_nxt.od      = reg_wdata_i[PIN_N-1:0];
			if (hit(reg_addr_i, REG_SRC_ADJ)) s_nxt.src_adj = reg_wdata_i[PIN_N-1:0];
			if (hit(reg_addr_i, REG_FAST))    s_nxt.fast    = reg_wdata_i[PIN_N-1:0];
			if (hit(reg_addr_i, REG_CTRL))    s_nxt.ctrl    = reg_wdata_i[1:0];
		end

		// register reads, unmapped reads return zero
		if (reg_rd_i) begin
			if (hit(reg_addr_i, REG_DIR_OUT)) s_nxt.rdata[PIN_N-1:0] = s_r.dir_out;
			if (hit(reg_addr_i, REG_DIR_IN))  s_nxt.rdata[PIN_N-1:0] = s_r.dir_in;
			if (hit(reg_addr_i, REG_INV_D))   s_nxt.rdata[PIN_N-1:0] = s_r.inv_d;
			if (hit(reg_addr_i, REG_INV_OE))  s_nxt.rdata[PIN_N-1:0] = s_r.inv_oe;
			if (hit(reg_addr_i, REG_OD))      s_nxt.rdata[PIN_N-1:0] = s_r.od;
			if (hit(reg_addr_i, REG_SRC_ADJ)) s_nxt.rdata[PIN_N-1:0] = s_r.src_adj;
			if (hit(reg_addr_i, REG_FAST))    s_nxt.rdata[PIN_N-1:0] = s_r.fast;
			if (hit(reg_addr_i, REG_CTRL))    s_nxt.rdata[1:0]       = s_r.ctrl;
			if (hit(reg_addr_i, REG_PIN_IN))  s_nxt.rdata[PIN_N-1:0] = pin_in_i;
			if (hit(reg_addr_i, REG_STATUS)) begin
				s_nxt.rdata[STAT_PWR]        = supply_ok_i;
				s_nxt.rdata[STAT_DIS]        = dis_act;
				s_nxt.rdata[STAT_IR +: IR_W] = s_r.ir;
				s_nxt.rdata[STAT_TAP +: 16]  = s_r.tap;
			end
		end

		// tap actions on a tck rising edge
		if (tck_rise) begin
			unique case (s_r.tap)
				TAP_CAPIR: s_nxt.ir_sh = {{(IR_W-2){1'b0}}, IR_CAP_VAL};
				TAP_SHIR:  s_nxt.ir_sh = {tdi_i, s_r.ir_sh[IR_W-1:1]};
				TAP_UPDIR: s_nxt.ir    = s_r.ir_sh;
				TAP_CAPDR: begin
					s_nxt.byp = 1'b0;
					// snapshot of pins and core drive, pads untouched
					if (bsr_sel) s_nxt.bsr_sh = cap_vec;
				end
				TAP_SHDR: begin
					if (!bsr_sel) s_nxt.byp = tdi_i;
					else if (BSR_REV) s_nxt.bsr_sh = {s_r.bsr_sh[BSR_LEN-2:0], tdi_i};
					else s_nxt.bsr_sh = {tdi_i, s_r.bsr_sh[BSR_LEN-1:1]};
				end
				// preload lands in the update stage for later use
				TAP_UPDDR: if (bsr_sel) s_nxt.bsr_up = s_r.bsr_sh;
				default: ;
			endcase
			s_nxt.tap = tap_step(s_r.tap, tms_i);
		end

		// tdo changes on the falling edge and floats outside shifts
		if (tck_fall) begin
			s_nxt.tdo_oe = (s_r.tap == TAP_SHIR) || (s_r.tap == TAP_SHDR);
			if (s_r.tap == TAP_SHIR) s_nxt.tdo = s_r.ir_sh[0];
			else if (!bsr_sel) s_nxt.tdo = s_r.byp;
			else s_nxt.tdo = BSR_REV ? s_r.bsr_sh[BSR_LEN-1] : s_r.bsr_sh[0];
		end

		// test-logic-reset selects bypass
		if (s_r.tap == TAP_TLR) s_nxt.ir = OP_BYP;

		// scan refused while configuring
		if (scan_hold) begin
			s_nxt.tap    = TAP_TLR;
			s_nxt.tdo_oe = 1'b0;
		end

		// pad drive
		for (int i = 0; i < PIN_N; i++) begin
			s_nxt.pad.out[i] = core_d[i];
			s_nxt.pad.oe[i]  = core_oe[i];
			if (s_r.ir == OP_EXT) begin
				s_nxt.pad.out[i] = ext_d[i];
				s_nxt.pad.oe[i]  = ext_oe[i];
			end
			if (s_r.od[i]) s_nxt.pad.out[i] = 1'b0;
			if (dis_act || !supply_ok_i) s_nxt.pad.oe[i] = 1'b0;
		end

		// input buffers toward the logic cells
		s_nxt.core_in = pin_in_i & s_r.dir_in;

		// reset values
		if (!resetn_i) begin
			s_nxt         = '0;
			s_nxt.dir_out = CFG_RST;
			s_nxt.dir_in  = CFG_RST;
			s_nxt.ctrl    = CTRL_RST;
			s_nxt.tap     = TAP_TLR;
			s_nxt.ir      = OP_BYP;
			// follow the pin so a high idle tck gives no false rise at release
			s_nxt.tck_q   = tck_i;
		end
	end

	// state register
	always_ff @(posedge core_clk_i) begin
		s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign reg_rdata_o = s_r.rdata;
	assign core_in_o   = s_r.core_in;
	assign pad_o       = s_r.pad;
	assign tdo_o       = s_r.tdo;
	assign tdo_oe_o    = s_r.tdo_oe;

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	chk_od_never_high: assert property (
		(pad_o.oe & pad_o.out & $past(s_r.od)) == '0
	) else $error("open-drain pin driven high");

	chk_disable_all_off: assert property (
		dis_act |=> pad_o.oe == '0
	) else $error("pin enabled while chip disable active");

	chk_power_up_float: assert property (
		!supply_ok_i |=> pad_o.oe == '0
	) else $error("pin driven before supply ok");

	chk_bypass_pass_bit: assert property (
		(tck_rise && s_r.tap == TAP_SHDR && !bsr_sel && !scan_hold)
		|=> s_r.byp == $past(tdi_i)
	) else $error("bypass bit did not take tdi");

	chk_tlr_ir_bypass: assert property (
		s_r.tap == TAP_TLR |=> s_r.ir == OP_BYP
	) else $error("reset state did not select bypass");

	chk_cfg_scan_hold: assert property (
		scan_hold |=> (s_r.tap == TAP_TLR) && !tdo_oe_o
	) else $error("scan active during configuration");

	chk_extest_pad_drive: assert property (
		(s_r.ir == OP_EXT && supply_ok_i && !dis_act)
		|=> pad_o.oe == $past(ext_oe) && pad_o.out == $past(ext_d & ~s_r.od)
	) else $error("extest pattern not on pads");

	chk_sample_snapshot: assert property (
		(tck_rise && s_r.tap == TAP_CAPDR && s_r.ir == OP_SMP && !scan_hold)
		|=> sh_in == $past(pin_in_i)
	) else $error("sample capture missed pin levels");

	chk_ir_capture_code: assert property (
		(tck_rise && s_r.tap == TAP_CAPIR && !scan_hold)
		|=> s_r.ir_sh[1:0] == IR_CAP_VAL
	) else $error("instruction capture code wrong");

	chk_ir_update_load: assert property (
		(tck_rise && s_r.tap == TAP_UPDIR && !scan_hold)
		|=> s_r.ir == $past(s_r.ir_sh)
	) else $error("instruction not loaded on update");

	chk_tdo_float_idle: assert property (
		(tck_fall && s_r.tap != TAP_SHIR && s_r.tap != TAP_SHDR)
		|=> !tdo_oe_o
	) else $error("tdo driven outside a shift state");

	chk_preload_held: assert property (
		!(tck_rise && s_r.tap == TAP_UPDDR)
		|=> $stable(s_r.bsr_up)
	) else $error("update stage changed outside update");

	chk_enable_needs_dir: assert property (
		s_r.ir != OP_EXT
		|=> (pad_o.oe & ~$past(s_r.dir_out)) == '0
	) else $error("pin driven while not set as output");

	chk_fast_adjacent: assert property (
		s_r.ir != OP_EXT
		|=> ((pad_o.out ^ $past((lc_drive_i.adj_data ^ s_r.inv_d) & ~s_r.od))
		     & $past(s_r.fast)) == '0
	) else $error("fast pin not fed by adjacent logic cell");

	chk_core_in_gate: assert property (
		core_in_o == $past(pin_in_i & s_r.dir_in)
	) else $error("input buffer gating wrong");

endmodule : pioscn_top

`default_nettype wire

// File: verif/pioscn_board.sv
// pioscn_board: board side of the pin array, pull-ups plus an external driver
// assumes: every trace has a pull-up; the external driver acts only where enabled
`timescale 1ns/100ps
`default_nettype none
module pioscn_board
	import pioscn_pkg::*;
(
	// device pads
	input  wire pioscn_pad_t      pad_i,
	// external driver
	input  wire logic [PIN_N-1:0] ext_en_i,
	input  wire logic [PIN_N-1:0] ext_val_i,
	// resolved trace level
	output var  logic [PIN_N-1:0] wire_o
);
	// device drive wins, else the external driver, else the pull-up lifts the trace
	always_comb begin
		for (int i = 0; i < PIN_N; i++) begin
			wire_o[i] = pad_i.oe[i] ? pad_i.out[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
		end
	end
endmodule : pioscn_board
`default_nettype wire

// File: verif/tb.sv
// tb: self-checking bench for the pin cell array and its scan port
// assumes: design defaults for opcodes, scan order and disable polarity
`timescale 1ns/100ps
`default_nettype none
module tb
	import pioscn_pkg::*;
;
	typedef struct packed {
		logic [55:0] cfg;
		pioscn_lc_t  lc;
		pioscn_pad_t pad;
		logic [7:0]  cin;
	} pioscn_row_t;
	// config bytes fast..dir_out, drive, expected pads and core inputs
	localparam pioscn_row_t ROWS [6] = '{
		'{56'h00_00_00_00_00_00_ff, 32'ha5ff3c0f, 16'ha5ff, 8'h00},
		'{56'h00_ff_00_00_00_00_ff, 32'ha5ff3c0f, 16'h3c0f, 8'h00},
		'{56'hf0_00_00_00_00_00_ff, 32'h00ffff00, 16'hf00f, 8'h00},
		'{56'h00_00_00_0f_ff_00_ff, 32'h00000000, 16'hff0f, 8'h00},
		'{56'h00_00_ff_00_00_ff_ff, 32'hff550000, 16'h0055, 8'haa},
		'{56'h00_00_00_00_00_00_0f, 32'hffff0000, 16'hff0f, 8'h00}};
	localparam logic [1:0]  CTL [3]  = '{2'h1, 2'h2, 2'h0};
	localparam logic [15:0] TAPX [3] = '{16'h0001, 16'h0001, 16'h0002};
	localparam logic [7:0]  PO       = 8'h5a;
	localparam logic [7:0]  PE       = 8'hf0;
	// clock, reset, register port, pins and scan port
	logic              core_clk_i, resetn_i, reg_wr_i, reg_rd_i;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, d;
	pioscn_lc_t        lc;
	pioscn_pad_t       pad;
	logic [PIN_N-1:0]  core_in, pins, ext_en, ext_val, cap;
	logic              dis, sup, tck_i, tms_i, tdi_i, tdo_o, tdo_oe, o;
	logic [23:0]       pre, dout;
	int                miscompares, total_checks;

	pioscn_top dut (
		.core_clk_i                 (core_clk_i),
		.resetn_i                   (resetn_i),
		.reg_addr_i                 (reg_addr_i),
		.reg_wdata_i                (reg_wdata_i),
		.reg_wr_i                   (reg_wr_i),
		.reg_rd_i                   (reg_rd_i),
		.reg_rdata_o                (reg_rdata_o),
		.lc_drive_i                 (lc),
		.core_in_o                  (core_in),
		.pin_in_i                   (pins),
		.pad_o                      (pad),
		.chip_wide_output_disable_i (dis),
		.supply_ok_i                (sup),
		.tck_i                      (tck_i),
		.tms_i                      (tms_i),
		.tdi_i                      (tdi_i),
		.tdo_o                      (tdo_o),
		.tdo_oe_o                   (tdo_oe)
	);
	pioscn_board board (
		.pad_i     (pad),
		.ext_en_i  (ext_en),
		.ext_val_i (ext_val),
		.wire_o    (pins)
	);

	// comparison, register and scan helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		reg_wr_i    <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i   <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	task automatic tclk(input logic m, input logic v);
		@(posedge core_clk_i);
		tck_i <= 1'b0;
		tms_i <= m;
		tdi_i <= v;
		repeat (3) @(posedge core_clk_i);
		#1 o = tdo_o;
		@(posedge core_clk_i);
		tck_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
	endtask : tclk
	// one ir or dr scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input int n, input logic [23:0] din);
		tclk(1'b1, 1'b0);
		if (ir)
			tclk(1'b1, 1'b0);
		tclk(1'b0, 1'b0);
		tclk(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			tclk(i == n - 1, din[i]);
			dout[i] = o;
			check(tdo_oe, 1'b1);
		end
		tclk(1'b1, 1'b0);
		tclk(1'b0, 1'b0);
		check(tdo_oe, 1'b0);
	endtask : scan
	task automatic do_reset();
		resetn_i <= 1'b0;
		repeat (20) @(posedge core_clk_i);
		#1 check(pad, 16'h0000);
		@(posedge core_clk_i);
		resetn_i <= 1'b1;
	endtask : do_reset
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	// core clock
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	// watchdog against a hang
	initial begin
		repeat (50000) @(posedge core_clk_i);
		miscompares++;
		give_verdict();
	end
	// main sequence
	initial begin
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		lc = '0;
		ext_en = '0;
		ext_val = 8'h96;
		dis = ~DIS_POL_DEF;
		sup = 1'b1;
		{tck_i, tms_i, tdi_i} = 3'b110;
		miscompares = 0;
		total_checks = 0;
		do_reset();
		foreach (ROWS[r]) begin
			for (int k = 0; k < 7; k++)
				wr(8'(4 * k), {24'h0, ROWS[r].cfg[8*k +: 8]});
			lc <= ROWS[r].lc;
			repeat (3) @(posedge core_clk_i);
			#1 check(pad, ROWS[r].pad);
			check(core_in, ROWS[r].cin);
		end
		// chip-wide disable, then supply loss
		@(posedge core_clk_i);
		dis <= DIS_POL_DEF;
		repeat (2) @(posedge core_clk_i);
		#1 check(pad.oe, 8'h00);
		rd(REG_STATUS);
		check(d[1:0], 2'b11);
		@(posedge core_clk_i);
		dis <= ~DIS_POL_DEF;
		sup <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1 check(pad.oe, 8'h00);
		@(posedge core_clk_i);
		sup <= 1'b1;
		// tms low across the release: a false tck rise would leave reset state
		tms_i <= 1'b0;
		do_reset();
		// reset values, read-only status, unmapped and narrow registers
		wr(REG_STATUS, 32'hffffffff);
		for (int k = 0; k < 8; k++) begin
			rd(8'(4 * k));
			check(d, 32'h0);
		end
		rd(REG_STATUS);
		check(d, {16'h0001, 4'h0, OP_BYP_DEF[3:0], 8'h01});
		rd(8'h30);
		check(d, 32'h0);
		wr(REG_DIR_OUT, 32'hffffffff);
		rd(REG_DIR_OUT);
		check(d, 32'h000000ff);
		wr(REG_DIR_OUT, 32'h0);
		// bypass, sample/preload, extest
		ext_en <= 8'hff;
		tclk(1'b0, 1'b0);
		scan(1'b0, 8, 24'hb4);
		check(dout[7:0], 8'h68);
		scan(1'b1, IR_LEN_DEF, {20'h0, OP_SMP_DEF[3:0]});
		check(dout[1:0], IR_CAP_VAL);
		for (int i = 0; i < PIN_N; i++)
			pre[3*i +: 3] = {PE[i], PO[i], 1'b0};
		scan(1'b0, BSR_LEN, pre);
		for (int i = 0; i < PIN_N; i++)
			cap[i] = dout[3 * i];
		check(cap, 8'h96);
		check(pad, 16'hff00);
		scan(1'b1, IR_LEN_DEF, {20'h0, OP_EXT_DEF[3:0]});
		check(pad, {PO, PE});
		scan(1'b0, BSR_LEN, pre);
		for (int i = 0; i < PIN_N; i++)
			cap[i] = dout[3 * i];
		check(cap, 8'h56);
		rd(REG_PIN_IN);
		check(d, 32'h56);
		// scan refused while configuring or switched off
		foreach (CTL[j]) begin
			wr(REG_CTRL, {30'h0, CTL[j]});
			tclk(1'b0, 1'b0);
			rd(REG_STATUS);
			check(d[31:16], TAPX[j]);
		end
		give_verdict();
	end
endmodule : tb
`default_nettype wire
